// >>> design/nsf_pkg.sv
package nsf_pkg;

    // Framing characters
    localparam logic [7:0] NSF_SOF = 8'h24;
    localparam logic [7:0] NSF_SEP = 8'h2C;
    localparam logic [7:0] NSF_CKD = 8'h2A;
    localparam logic [7:0] NSF_CR = 8'h0D;
    localparam logic [7:0] NSF_LF = 8'h0A;
    // Stands in for any byte that would break the framing
    localparam logic [7:0] NSF_SUB = 8'h3F;
    localparam logic [7:0] NSF_PRINT_LO = 8'h20;
    localparam logic [7:0] NSF_PRINT_HI = 8'h7E;
    localparam logic [7:0] NSF_HEX_DIGIT = 8'h30;
    localparam logic [7:0] NSF_HEX_ALPHA = 8'h37;
    localparam logic [3:0] NSF_HEX_TEN = 4'hA;
    // Address is two talker plus three type characters
    localparam logic [2:0] NSF_ADDR_LAST = 3'h4;
    localparam logic [2:0] NSF_TYPE_POS = 3'h2;

    typedef enum logic [2:0] {
        NSF_GGA = 3'h0,
        NSF_GLL = 3'h1,
        NSF_GSA = 3'h2,
        NSF_GSV = 3'h3,
        NSF_VTG = 3'h4,
        NSF_RMC = 3'h5,
        NSF_ZDA = 3'h6,
        NSF_GNS = 3'h7
    } nsf_type_e;

    // Letters of each sentence type, indexed by nsf_type_e
    localparam logic [23:0] NSF_TYPE_CODE [8] = '{
        24'h474741, 24'h474C4C, 24'h475341, 24'h475356,
        24'h565447, 24'h524D43, 24'h5A4441, 24'h474E53
    };

    typedef enum logic [7:0] {
        NSF_IDLE = 8'h01,
        NSF_ADDR = 8'h02,
        NSF_DATA = 8'h04,
        NSF_STAR = 8'h08,
        NSF_CKHI = 8'h10,
        NSF_CKLO = 8'h20,
        NSF_CRET = 8'h40,
        NSF_LFEED = 8'h80
    } nsf_state_e;

    typedef struct packed {
        logic [15:0] talker;
        nsf_type_e stype;
    } nsf_cmd_s;

    typedef struct packed {
        logic [7:0] data;
        logic void_beat;
        logic field_end;
        logic sentence_end;
    } nsf_fld_s;

    typedef struct packed {
        nsf_state_e st;
        logic [2:0] idx;
        logic [39:0] addr;
        nsf_type_e stype;
        logic [7:0] ck;
        logic fstart;
        logic [7:0] tx_byte;
        logic tx_valid;
        logic cmd_ready;
        logic fld_ready;
        logic bad_char;
        logic busy;
    } nsf_reg_s;

    localparam nsf_reg_s NSF_REG_RESET = '{
        st: NSF_IDLE, idx: 3'h0, addr: 40'h0, stype: NSF_GGA, ck: 8'h00,
        fstart: 1'b0, tx_byte: 8'h00, tx_valid: 1'b0, cmd_ready: 1'b1,
        fld_ready: 1'b0, bad_char: 1'b0, busy: 1'b0
    };

endpackage

// >>> design/nsf_framer.sv
`timescale 1ns/1ps
module nsf_framer (
    input wire logic mclk,
    input wire logic rst_n,
    input nsf_pkg::nsf_cmd_s cmd,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input nsf_pkg::nsf_fld_s fld,
    input wire logic fld_valid,
    output logic fld_ready,
    output logic [7:0] tx_byte,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic bad_char,
    output logic busy
);
    import nsf_pkg::*;

    nsf_reg_s s_r;
    nsf_reg_s s_nxt;

    // Map anything outside printable text, or a framing character, to SUB
    function automatic logic [7:0] nsf_clean(input logic [7:0] b);
        logic bad;
        bad = (b < NSF_PRINT_LO) || (b > NSF_PRINT_HI) ||
              (b == NSF_SOF) || (b == NSF_CKD) || (b == NSF_SEP);
        return bad ? NSF_SUB : b;
    endfunction

    // Upper-case hex digit
    function automatic logic [7:0] nsf_hex(input logic [3:0] n);
        logic [7:0] w;
        w = {4'h0, n};
        return (n < NSF_HEX_TEN) ? (w + NSF_HEX_DIGIT) :
            (w + NSF_HEX_ALPHA);
    endfunction

    // Next-state logic; one byte is launched only while the output is empty
    always_comb begin
        logic free;
        logic emit;
        logic [7:0] eb;
        logic [23:0] code;
        free = 1'b0;
        emit = 1'b0;
        eb = 8'h00;
        code = 24'h0;
        s_nxt = s_r;
        s_nxt.bad_char = 1'b0;
        free = ~s_r.tx_valid;
        if (s_r.tx_valid && tx_ready) begin
            s_nxt.tx_valid = 1'b0;
        end
        case (s_r.st)
            NSF_IDLE: begin
                if (cmd_valid && s_r.cmd_ready) begin
                    code = NSF_TYPE_CODE[cmd.stype];
                    eb = NSF_SOF;
                    emit = 1'b1;
                    s_nxt.addr = {nsf_clean(cmd.talker[15:8]),
                                  nsf_clean(cmd.talker[7:0]), code};
                    s_nxt.stype = cmd.stype;
                    s_nxt.ck = 8'h00;
                    s_nxt.idx = 3'h0;
                    s_nxt.fstart = 1'b1;
                    s_nxt.st = NSF_ADDR;
                end
            end
            NSF_ADDR: begin
                if (free) begin
                    eb = s_r.addr[39:32];
                    emit = 1'b1;
                    s_nxt.addr = {s_r.addr[31:0], 8'h00};
                    s_nxt.ck = s_r.ck ^ eb;
                    if (s_r.idx == NSF_ADDR_LAST) begin
                        s_nxt.st = NSF_DATA;
                    end else begin
                        s_nxt.idx = s_r.idx + 3'h1;
                    end
                end
            end
            NSF_DATA: begin
                if (free && s_r.fstart) begin
                    // Every field, the first too, is led by a separator
                    eb = NSF_SEP;
                    emit = 1'b1;
                    s_nxt.ck = s_r.ck ^ NSF_SEP;
                    s_nxt.fstart = 1'b0;
                end else if (fld_valid && s_r.fld_ready) begin
                    if (!fld.void_beat) begin
                        eb = nsf_clean(fld.data);
                        emit = 1'b1;
                        s_nxt.ck = s_r.ck ^ eb;
                        s_nxt.bad_char = (eb != fld.data);
                    end
                    if (fld.field_end) begin
                        s_nxt.fstart = 1'b1;
                    end
                    if (fld.sentence_end) begin
                        s_nxt.fstart = 1'b0;
                        s_nxt.st = NSF_STAR;
                    end
                end
            end
            NSF_STAR: begin
                if (free) begin
                    eb = NSF_CKD;
                    emit = 1'b1;
                    s_nxt.st = NSF_CKHI;
                end
            end
            NSF_CKHI: begin
                if (free) begin
                    eb = nsf_hex(s_r.ck[7:4]);
                    emit = 1'b1;
                    s_nxt.st = NSF_CKLO;
                end
            end
            NSF_CKLO: begin
                if (free) begin
                    eb = nsf_hex(s_r.ck[3:0]);
                    emit = 1'b1;
                    s_nxt.st = NSF_CRET;
                end
            end
            NSF_CRET: begin
                if (free) begin
                    eb = NSF_CR;
                    emit = 1'b1;
                    s_nxt.st = NSF_LFEED;
                end
            end
            NSF_LFEED: begin
                if (free) begin
                    eb = NSF_LF;
                    emit = 1'b1;
                    s_nxt.st = NSF_IDLE;
                end
            end
            default: begin
                s_nxt = NSF_REG_RESET;
            end
        endcase
        if (emit) begin
            s_nxt.tx_byte = eb;
            s_nxt.tx_valid = 1'b1;
        end
        // Readies are registered, so they look at the next output state;
        // this costs one idle cycle per byte, far below any UART rate
        s_nxt.cmd_ready = (s_nxt.st == NSF_IDLE) && !s_nxt.tx_valid;
        s_nxt.fld_ready = (s_nxt.st == NSF_DATA) && !s_nxt.fstart &&
                          !s_nxt.tx_valid;
        s_nxt.busy = (s_nxt.st != NSF_IDLE);
    end

    // State register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= NSF_REG_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cmd_ready = s_r.cmd_ready;
    assign fld_ready = s_r.fld_ready;
    assign tx_byte = s_r.tx_byte;
    assign tx_valid = s_r.tx_valid;
    assign bad_char = s_r.bad_char;
    assign busy = s_r.busy;

    // Output stays printable except for the terminator pair
    a_tx_printable: assert property (
        @(posedge mclk) disable iff (!rst_n)
        tx_valid |-> ((tx_byte >= NSF_PRINT_LO && tx_byte <= NSF_PRINT_HI)
            || tx_byte == NSF_CR || tx_byte == NSF_LF))
        else $error("non printable byte on output");

    // Accepted command launches the start byte next cycle
    a_start_byte: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (cmd_valid && cmd_ready) |=> (tx_valid && tx_byte == NSF_SOF))
        else $error("start byte missing after command");

    // First address character follows the start byte
    a_addr_follows: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (tx_valid && tx_ready && s_r.st == NSF_ADDR && s_r.idx == 3'h0)
        |=> ##1 (tx_valid && tx_byte == $past(s_r.addr[39:32], 2)))
        else $error("talker character not sent after start");

    // Third address character is the first letter of the type
    a_type_code: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (s_r.st == NSF_ADDR && s_r.idx == NSF_TYPE_POS && !tx_valid)
        |=> (tx_byte == NSF_TYPE_CODE[s_r.stype][23:16]))
        else $error("sentence type letter wrong");

    // Separator leads each field
    a_field_sep: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (s_r.st == NSF_DATA && s_r.fstart && !tx_valid)
        |=> (tx_valid && tx_byte == NSF_SEP && !fld_ready))
        else $error("field separator missing");

    // High checksum digit comes two cycles after the delimiter is taken
    a_cksum_hi: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (tx_valid && tx_ready && tx_byte == NSF_CKD)
        |=> ##1 (tx_valid && tx_byte == nsf_hex(s_r.ck[7:4])))
        else $error("checksum high digit wrong");

    // LF follows CR and the framer then returns to idle
    a_crlf_end: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (tx_valid && tx_ready && tx_byte == NSF_CR)
        |=> ##1 (tx_valid && tx_byte == NSF_LF && !busy))
        else $error("line feed not sent after carriage return");

    // CR comes straight after the low checksum digit
    a_cr_after_ck: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (s_r.st == NSF_CRET && tx_valid && tx_ready)
        |=> ##1 (tx_valid && tx_byte == NSF_CR))
        else $error("carriage return not after checksum");

endmodule

// >>> sim/nsf_sink.sv
`timescale 1ns/1ps
module nsf_sink (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic slow,
    output logic tx_ready
);
    logic [1:0] cnt_r;
    // UART side; when slow it takes one byte in four cycles
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 2'h0;
            tx_ready <= 1'b0;
        end else begin
            cnt_r <= #1 cnt_r + 2'h1;
            tx_ready <= #1 !slow || (cnt_r == 2'h3);
        end
    end
endmodule

// >>> sim/nmea_sentence_framer_bench.sv
`timescale 1ns/1ps
module nmea_sentence_framer_bench;
    import nsf_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic slow = 1'b0;
    logic cmd_valid = 1'b0;
    logic fld_valid = 1'b0;
    nsf_cmd_s cmd = '0;
    nsf_fld_s fld = '0;
    logic cmd_ready, fld_ready, tx_valid, tx_ready, bad_char, busy;
    logic [7:0] tx_byte;
    logic [31:0] lfsr_r = 32'd79139;
    logic [7:0] exp_q [$];
    logic [7:0] e_b;
    int failures = 0;
    int n_checks = 0;
    int n_bad = 0;

    always #4 mclk = ~mclk;

    nsf_framer u_nsf_framer (.mclk(mclk), .rst_n(rst_n), .cmd(cmd),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .fld(fld),
        .fld_valid(fld_valid), .fld_ready(fld_ready), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .bad_char(bad_char),
        .busy(busy));
    nsf_sink u_nsf_sink (.mclk(mclk), .rst_n(rst_n), .slow(slow),
        .tx_ready(tx_ready));

    task automatic give_verdict();
        if (failures == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] e,
                         input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    function automatic logic [7:0] clean(input logic [7:0] b);
        if (b < 8'h20 || b > 8'h7E || b == 8'h24 || b == 8'h2A
            || b == 8'h2C) begin
            return 8'h3F;
        end
        return b;
    endfunction

    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction

    function automatic logic [7:0] rnd();
        lfsr_r = lfsr_r[0] ? (lfsr_r >> 1) ^ 32'h80200003 : lfsr_r >> 1;
        return lfsr_r[7:0];
    endfunction

    // Every byte handed off is compared with the model in order
    always @(posedge mclk) begin
        if (rst_n && tx_valid && tx_ready) begin
            if (exp_q.size() == 0) begin
                check("surplus byte", 8'h00, 8'h01);
            end else begin
                e_b = exp_q.pop_front();
                check("tx_byte", e_b, tx_byte);
                // Only the closing LF goes out with the framer back in idle
                check("busy", {7'h0, e_b != 8'h0A}, {7'h0, busy});
            end
        end
        if (rst_n && bad_char) begin
            n_bad++;
        end
    end

    // One field beat, held until the framer takes it
    task automatic beat(input logic [7:0] d, input logic v,
                        input logic fe, input logic se);
        int g;
        #1;
        cmd_valid = 1'b0;
        fld = '{d, v, fe, se};
        fld_valid = 1'b1;
        g = 0;
        do begin
            @(posedge mclk);
            g++;
        end while (fld_ready !== 1'b1 && g < 300);
        if (g >= 300) begin
            check("fld_ready wait", 8'h01, 8'h00);
        end
    endtask

    task automatic sentence(input logic [15:0] tk, input nsf_type_e t,
                            input int nf);
        logic [7:0] ck, b;
        int n, sub, n0, g;
        ck = 8'h00;
        sub = 0;
        n0 = n_bad;
        exp_q.push_back(8'h24);
        for (int i = 1; i >= 0; i--) begin
            b = clean(tk[8*i+:8]);
            exp_q.push_back(b);
            ck ^= b;
        end
        for (int i = 2; i >= 0; i--) begin
            b = NSF_TYPE_CODE[t][8*i+:8];
            exp_q.push_back(b);
            ck ^= b;
        end
        #1;
        cmd = '{tk, t};
        cmd_valid = 1'b1;
        g = 0;
        do begin
            @(posedge mclk);
            g++;
        end while (cmd_ready !== 1'b1 && g < 300);
        if (g >= 300) begin
            check("cmd_ready wait", 8'h01, 8'h00);
        end
        // Field loop: empty fields give a void beat, a comma still goes out
        for (int f = 0; f < nf; f++) begin
            exp_q.push_back(8'h2C);
            ck ^= 8'h2C;
            n = int'(rnd() % 4);
            if (n == 0) begin
                beat(8'h00, 1'b1, f < nf - 1, f == nf - 1);
            end
            for (int j = 0; j < n; j++) begin
                b = rnd() & 8'h7F;
                if (clean(b) != b) begin
                    sub++;
                end
                exp_q.push_back(clean(b));
                ck ^= clean(b);
                beat(b, 1'b0, j == n - 1 && f < nf - 1,
                     j == n - 1 && f == nf - 1);
            end
        end
        #1 fld_valid = 1'b0;
        exp_q.push_back(8'h2A);
        exp_q.push_back(hexc(ck[7:4]));
        exp_q.push_back(hexc(ck[3:0]));
        exp_q.push_back(8'h0D);
        exp_q.push_back(8'h0A);
        g = 0;
        while (exp_q.size() != 0 && g < 2000) begin
            @(posedge mclk);
            g++;
        end
        repeat (3) @(posedge mclk);
        #1;
        check("queue left", 8'h00, 8'(exp_q.size()));
        check("busy", 8'h00, {7'h0, busy});
        check("cmd_ready", 8'h01, {7'h0, cmd_ready});
        check("bad_char count", 8'(sub), 8'(n_bad - n0));
    endtask

    // Main sequence: all types, then a stalling sink and a bad talker
    initial begin
        repeat (6) @(posedge mclk);
        #1 rst_n = 1'b1;
        for (int t = 0; t < 8; t++) begin
            sentence(16'h474E, nsf_type_e'(t), 1 + t % 3);
        end
        slow = 1'b1;
        sentence(16'h0A50, NSF_GGA, 4);
        sentence(16'h4750, NSF_RMC, 1);
        give_verdict();
    end

    // Watchdog, far beyond the few hundred cycles expected
    initial begin
        #400000;
        failures++;
        give_verdict();
    end
endmodule
